/* dv/tb_boot_config_word_decode.sv */
module tb_boot_config_word_decode;
  timeunit 1ns;
  timeprecision 1ns;
  // Clock, reset and inputs.
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [31:0] flash_word_zero = 32'h0000_0000;
  logic [31:0] flash_word_two = 32'h0000_0000;
  logic code_protect = 1'b0;
  logic [3:0] address = 4'h0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0000_0000;
  logic [3:0] byteenable = 4'h0;
  logic [20:0] flash_write_addr = 21'h00_0000;
  logic flash_write_req = 1'b0;
  // Outputs.
  logic [31:0] readdata;
  logic [20:0] protect_boundary;
  logic [1:0] debug_channel_select, debugger_field;
  logic waitrequest, flash_write_block, debug_pair_one, debug_pair_two, debug_pair_three;
  logic scan_port_enable, debugger_enable, settings_valid;
  logic [2:0] pll_input_divider;
  logic [3:0] pll_divide_ratio;
  // Bench bookkeeping.
  logic snap = 1'b0;
  logic [63:0] notes[$];
  int n_errors = 0;
  int n_compared = 0;

  always #50 sys_clk = ~sys_clk;

  boot_config_word_decode DUT (
    .sys_clk, .rst, .flash_word_zero, .flash_word_two, .code_protect,
    .address, .read, .write, .writedata, .byteenable, .readdata, .waitrequest,
    .flash_write_addr, .flash_write_req, .flash_write_block, .protect_boundary,
    .debug_channel_select, .debug_pair_one, .debug_pair_two, .debug_pair_three,
    .scan_port_enable, .debugger_field, .debugger_enable, .pll_input_divider,
    .pll_divide_ratio, .settings_valid
  );

  task automatic complete_run();
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : complete_run

  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // The ratio table is written out here so the bench never leans on the design's own function.
  function automatic logic [63:0] exp_dec(input logic [31:0] w0, input logic [31:0] w2,
                                          input logic cp);
    logic [3:0] rt [8];
    logic [20:0] b;
    rt = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'hA, 4'hC};
    b = w0[24] ? 21'h00_0000 : {1'b0, ~w0[19:10], 10'h000};
    return {27'h000_0000, b, w0[4:3], w0[4:3] == 2'h3, w0[4:3] == 2'h2, w0[4:3] == 2'h1,
            w0[2], cp ? 2'h3 : w0[1:0], !cp && !w0[1], w2[2:0], rt[w2[2:0]]};
  endfunction : exp_dec

  always @(posedge sys_clk) begin
    if (snap && notes.size() > 0) begin
      check({27'h000_0000, protect_boundary, debug_channel_select, debug_pair_one,
             debug_pair_two, debug_pair_three, scan_port_enable, debugger_field,
             debugger_enable, pll_input_divider, pll_divide_ratio}, notes.pop_front());
    end
    if (read && waitrequest === 1'b0 && notes.size() > 0) begin
      check({32'h0000_0000, readdata}, notes.pop_front());
    end
    if (flash_write_req && notes.size() > 0) begin
      check({63'h0, flash_write_block}, notes.pop_front());
    end
  end

  task automatic note_snap(input logic [63:0] e);
    notes.push_back(e);
    snap <= 1'b1;
    @(posedge sys_clk);
    snap <= 1'b0;
    @(posedge sys_clk);
  endtask : note_snap

  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                     input logic [3:0] be);
    int k;
    k = 0;
    address <= a;
    writedata <= d;
    byteenable <= be;
    read <= !wr;
    write <= wr;
    do begin
      @(posedge sys_clk);
      k++;
    end while (waitrequest !== 1'b0 && k < 20);
    if (k >= 20) begin
      n_errors++;
      complete_run();
    end
    read <= 1'b0;
    write <= 1'b0;
    @(posedge sys_clk);
  endtask : bus

  task automatic bus_rd(input logic [3:0] a, input logic [31:0] e);
    notes.push_back({32'h0000_0000, e});
    bus(1'b0, a, 32'h0000_0000, 4'hF);
  endtask : bus_rd

  task automatic guard(input logic [20:0] a, input logic e);
    notes.push_back({63'h0, e});
    flash_write_addr <= a;
    flash_write_req <= 1'b1;
    @(posedge sys_clk);
    flash_write_req <= 1'b0;
    @(posedge sys_clk);
  endtask : guard

  initial begin
    logic [31:0] w0, w2, wd;
    logic [63:0] e;
    logic [20:0] b, a;
    logic cp;
    int k;
    void'($urandom(67));
    for (int i = 0; i < 8; i++) begin
      w0 = $urandom();
      w2 = $urandom();
      cp = 1'($urandom_range(0, 1));
      w0[4:3] = i[1:0];
      w2[2:0] = i[2:0];
      w0[24] = (i == 5);
      if (i < 3) begin
        w0[19:10] = (i == 0) ? 10'h3FE : (i == 1) ? 10'h000 : 10'h3FF;
      end
      // Words are set while reset is held so the synchronisers settle before release.
      rst <= 1'b1;
      flash_word_zero <= w0;
      flash_word_two <= w2;
      code_protect <= cp;
      @(posedge sys_clk);
      note_snap({54'h00_0000_0000_0000, 2'h3, 1'b0, 3'h0, 4'h1});
      @(posedge sys_clk);
      rst <= 1'b0;
      k = 0;
      while (settings_valid !== 1'b1) begin
        @(posedge sys_clk);
        k++;
        if (k > 10) begin
          n_errors++;
          complete_run();
        end
      end
      e = exp_dec(w0, w2, cp);
      b = e[36:16];
      note_snap(e);
      bus_rd(4'h0, w0);
      bus_rd(4'h4, w2);
      bus_rd(4'h8, {31'h0, w0[2]});
      bus_rd(4'hC, {29'h0, !cp && !w0[1], cp, 1'b1});
      bus(1'b1, 4'h0, ~w0, 4'hF);
      bus_rd(4'h0, w0);
      wd = $urandom();
      bus(1'b1, 4'h8, wd, 4'hE);
      bus_rd(4'h8, {31'h0, w0[2]});
      bus(1'b1, 4'h8, wd, 4'hF);
      bus_rd(4'h8, {31'h0, wd[0]});
      a = 21'($urandom());
      guard(b - 21'h00_0001, b != 21'h00_0000);
      guard(b, 1'b0);
      guard(21'h00_0000, b != 21'h00_0000);
      guard(a, a < b);
      // Changing the words after load must not disturb the held settings.
      flash_word_zero <= ~w0;
      flash_word_two <= ~w2;
      repeat (3) @(posedge sys_clk);
      note_snap(e);
    end
    complete_run();
  end
endmodule : tb_boot_config_word_decode

/* verilog/boot_cfg_pkg.sv */
package boot_cfg_pkg;
  // Configuration word zero field positions.
  localparam int PROT_LSB = 10;
  localparam int PROT_W = 10;
  localparam int BOOT_PROT_BIT = 24;
  localparam int CHAN_LSB = 3;
  localparam int CHAN_W = 2;
  localparam int SCAN_BIT = 2;
  localparam int DBG_LSB = 0;
  localparam int DBG_W = 2;
  // Configuration word two field positions.
  localparam int PLLDIV_LSB = 0;
  localparam int PLLDIV_W = 3;
  // Flash page size in bytes and protect address width.
  localparam logic [20:0] PAGE_BYTES = 21'h00_0400;
  localparam int FADDR_W = 21;
  localparam logic [1:0] DBG_FORCED = 2'h3;
  // Register offsets (byte addresses).
  localparam logic [3:0] OFS_WORD_ZERO = 4'h0;
  localparam logic [3:0] OFS_WORD_TWO = 4'h4;
  localparam logic [3:0] OFS_RUNTIME = 4'h8;
  localparam logic [3:0] OFS_STATUS = 4'hC;
  localparam int RT_SCAN_BIT = 0;
  localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

  typedef enum logic [1:0] {
    CHAN_RESERVED,
    CHAN_PAIR_THREE,
    CHAN_PAIR_TWO,
    CHAN_PAIR_ONE
  } chan_t;

  // Divide ratio table indexed by the pll input divider code.
  function automatic logic [3:0] pll_ratio(input logic [2:0] code);
    logic [3:0] r;
    r = 4'h1;
    unique case (code)
      3'h0: r = 4'h1;
      3'h1: r = 4'h2;
      3'h2: r = 4'h3;
      3'h3: r = 4'h4;
      3'h4: r = 4'h5;
      3'h5: r = 4'h6;
      3'h6: r = 4'hA;
      3'h7: r = 4'hC;
    endcase
    return r;
  endfunction : pll_ratio
endpackage : boot_cfg_pkg

/* verilog/boot_config_word_decode.sv */
module boot_config_word_decode (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst,
  // Configuration words from flash and code protection state.
  input wire logic [31:0] flash_word_zero,
  input wire logic [31:0] flash_word_two,
  input wire logic code_protect,
  // Avalon-MM slave.
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Flash write guard.
  input wire logic [20:0] flash_write_addr,
  input wire logic flash_write_req,
  output logic flash_write_block,
  output logic [20:0] protect_boundary,
  // Decoded settings.
  output logic [1:0] debug_channel_select,
  output logic debug_pair_one,
  output logic debug_pair_two,
  output logic debug_pair_three,
  output logic scan_port_enable,
  output logic [1:0] debugger_field,
  output logic debugger_enable,
  output logic [2:0] pll_input_divider,
  output logic [3:0] pll_divide_ratio,
  output logic settings_valid
);
  cfg_settings_if cfg ();
  logic [31:0] fw0_s1, fw0_s2, fw2_s1, fw2_s2;
  logic cp_s1, cp_s2;
  logic runtime_scan;
  logic ack;
  boot_cfg_pkg::chan_t chan;
  logic [1:0] dbg_raw;

  // Flash words and strap arrive from outside the clock domain.
  // The synchronisers keep running through reset, so the latch sees settled words at release.
  always_ff @(posedge sys_clk) begin
    fw0_s1 <= flash_word_zero;
    fw0_s2 <= fw0_s1;
    fw2_s1 <= flash_word_two;
    fw2_s2 <= fw2_s1;
    cp_s1 <= code_protect;
    cp_s2 <= cp_s1;
  end

  cfg_word_latch u_latch (
    .sys_clk(sys_clk),
    .rst(rst),
    .flash_word_zero(fw0_s2),
    .flash_word_two(fw2_s2),
    .cfg(cfg.producer)
  );

  flash_guard u_guard (
    .sys_clk(sys_clk),
    .rst(rst),
    .cfg(cfg.consumer),
    .write_addr(flash_write_addr),
    .write_req(flash_write_req),
    .write_block(flash_write_block),
    .boundary(protect_boundary)
  );

  assign chan = boot_cfg_pkg::chan_t'(cfg.word_zero[boot_cfg_pkg::CHAN_LSB +: boot_cfg_pkg::CHAN_W]);
  assign dbg_raw = cfg.word_zero[boot_cfg_pkg::DBG_LSB +: boot_cfg_pkg::DBG_W];

  // Decoded outputs are registered; all but debugger_field and debugger_enable, which follow cp_s2, stay steady between resets.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      debug_channel_select <= 2'h0;
      debug_pair_one <= 1'b0;
      debug_pair_two <= 1'b0;
      debug_pair_three <= 1'b0;
      scan_port_enable <= 1'b0;
      debugger_field <= boot_cfg_pkg::DBG_FORCED;
      debugger_enable <= 1'b0;
      pll_input_divider <= 3'h0;
      pll_divide_ratio <= 4'h1;
      settings_valid <= 1'b0;
    end else begin
      settings_valid <= cfg.loaded;
      debug_channel_select <= cfg.word_zero[boot_cfg_pkg::CHAN_LSB +: boot_cfg_pkg::CHAN_W];
      debug_pair_one <= cfg.loaded && chan == boot_cfg_pkg::CHAN_PAIR_ONE;
      debug_pair_two <= cfg.loaded && chan == boot_cfg_pkg::CHAN_PAIR_TWO;
      debug_pair_three <= cfg.loaded && chan == boot_cfg_pkg::CHAN_PAIR_THREE;
      scan_port_enable <= cfg.loaded && cfg.word_zero[boot_cfg_pkg::SCAN_BIT];
      // Code protection overrides whatever was programmed in the field.
      debugger_field <= cp_s2 ? boot_cfg_pkg::DBG_FORCED : dbg_raw;
      debugger_enable <= cfg.loaded && !cp_s2 && !dbg_raw[1];
      pll_input_divider <= cfg.word_two[boot_cfg_pkg::PLLDIV_LSB +: boot_cfg_pkg::PLLDIV_W];
      pll_divide_ratio <= boot_cfg_pkg::pll_ratio(
        cfg.word_two[boot_cfg_pkg::PLLDIV_LSB +: boot_cfg_pkg::PLLDIV_W]);
    end
  end

  // Runtime scan enable: seeded from the word at load, software may change it later.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      runtime_scan <= 1'b0;
    end else if (cfg.loaded && !settings_valid) begin
      runtime_scan <= cfg.word_zero[boot_cfg_pkg::SCAN_BIT];
    end else if (write && ack && address == boot_cfg_pkg::OFS_RUNTIME && byteenable[0]) begin
      runtime_scan <= writedata[boot_cfg_pkg::RT_SCAN_BIT];
    end
  end

  // Every access takes one wait cycle, then completes; data is registered.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ack <= 1'b0;
      readdata <= 32'h0000_0000;
    end else begin
      ack <= (read || write) && !ack;
      if (read && !ack) begin
        unique case (address)
          boot_cfg_pkg::OFS_WORD_ZERO: readdata <= cfg.word_zero;
          boot_cfg_pkg::OFS_WORD_TWO: readdata <= cfg.word_two;
          boot_cfg_pkg::OFS_RUNTIME: readdata <= {31'h0000_0000, runtime_scan};
          boot_cfg_pkg::OFS_STATUS: readdata <= {29'h0000_0000, debugger_enable,
                                                 cp_s2, settings_valid};
          default: readdata <= boot_cfg_pkg::UNMAPPED_READ;
        endcase
      end
    end
  end
  assign waitrequest = (read || write) && !ack;

  a_pair_one_code: assert property (@(posedge sys_clk) disable iff (rst)
    cfg.loaded && chan == boot_cfg_pkg::CHAN_PAIR_ONE |=> debug_pair_one && !debug_pair_two)
    else $error("pair one not selected for code 11");
  a_reserved_chan: assert property (@(posedge sys_clk) disable iff (rst)
    chan == boot_cfg_pkg::CHAN_RESERVED |=> !debug_pair_one && !debug_pair_two
      && !debug_pair_three)
    else $error("reserved channel code selected a pair");
  a_scan_follows: assert property (@(posedge sys_clk) disable iff (rst)
    cfg.loaded |=> scan_port_enable == $past(cfg.word_zero[boot_cfg_pkg::SCAN_BIT]))
    else $error("scan enable does not follow word bit");
  a_debug_forced: assert property (@(posedge sys_clk) disable iff (rst)
    cp_s2 |=> debugger_field == boot_cfg_pkg::DBG_FORCED && !debugger_enable)
    else $error("debugger not forced off under code protection");
  a_debug_enable: assert property (@(posedge sys_clk) disable iff (rst)
    cfg.loaded && !cp_s2 && !dbg_raw[1] |=> debugger_enable)
    else $error("debugger not enabled for upper bit zero");
  a_pll_ratio_max: assert property (@(posedge sys_clk) disable iff (rst)
    cfg.word_two[boot_cfg_pkg::PLLDIV_LSB +: boot_cfg_pkg::PLLDIV_W] == 3'h7
      |=> pll_divide_ratio == 4'hC)
    else $error("code 111 does not give ratio 12");
  a_pll_ratio_six: assert property (@(posedge sys_clk) disable iff (rst)
    cfg.word_two[boot_cfg_pkg::PLLDIV_LSB +: boot_cfg_pkg::PLLDIV_W] == 3'h6
      |=> pll_divide_ratio == 4'hA)
    else $error("code 110 does not give ratio 10");
  a_load_in_time: assert property (@(posedge sys_clk) disable iff (rst)
    !cfg.loaded |=> cfg.loaded ##1 settings_valid)
    else $error("settings not valid within two cycles");
  a_valid_stays: assert property (@(posedge sys_clk) disable iff (rst)
    settings_valid |=> settings_valid && $stable(pll_input_divider))
    else $error("settings changed after load");
  a_bus_answer: assert property (@(posedge sys_clk) disable iff (rst)
    (read || write) && !ack |=> ack)
    else $error("bus answer late");

  c_pair_two: cover property (@(posedge sys_clk) disable iff (rst) debug_pair_two);
  c_block: cover property (@(posedge sys_clk) disable iff (rst) flash_write_block);
  c_forced: cover property (@(posedge sys_clk) disable iff (rst) cp_s2 && settings_valid);
  c_rt_write: cover property (@(posedge sys_clk) disable iff (rst)
    write && ack && address == boot_cfg_pkg::OFS_RUNTIME);
endmodule : boot_config_word_decode

/* verilog/cfg_settings_if.sv */
interface cfg_settings_if;
  logic [31:0] word_zero;
  logic [31:0] word_two;
  logic loaded;
  modport producer (output word_zero, output word_two, output loaded);
  modport consumer (input word_zero, input word_two, input loaded);
endinterface : cfg_settings_if

/* verilog/cfg_word_latch.sv */
module cfg_word_latch (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst,
  // Raw words from flash.
  input wire logic [31:0] flash_word_zero,
  input wire logic [31:0] flash_word_two,
  // Held copies.
  cfg_settings_if.producer cfg
);
  // The words are captured by a clock edge after release, never by the reset itself.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cfg.loaded <= 1'b0;
      cfg.word_zero <= 32'h0000_0000;
      cfg.word_two <= 32'h0000_0000;
    end else if (!cfg.loaded) begin
      cfg.loaded <= 1'b1;
      cfg.word_zero <= flash_word_zero;
      cfg.word_two <= flash_word_two;
    end
  end

  a_words_hold_after: assert property (@(posedge sys_clk) disable iff (rst)
    $past(cfg.loaded) |-> $stable(cfg.word_zero) && $stable(cfg.word_two))
    else $error("configuration words changed after load");
endmodule : cfg_word_latch

/* verilog/flash_guard.sv */
module flash_guard (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst,
  // Held configuration.
  cfg_settings_if.consumer cfg,
  // Flash write request from code execution.
  input wire logic [20:0] write_addr,
  input wire logic write_req,
  output logic write_block,
  output logic [20:0] boundary
);
  logic [9:0] field;
  logic [9:0] pages;
  logic active;
  assign field = cfg.word_zero[boot_cfg_pkg::PROT_LSB +: boot_cfg_pkg::PROT_W];
  assign pages = ~field;
  // All zeros inverts to the largest count, 1023 pages, so protection covers byte addresses below 0xFFC00.
  assign active = cfg.loaded && !cfg.word_zero[boot_cfg_pkg::BOOT_PROT_BIT];
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      boundary <= 21'h00_0000;
    end else begin
      boundary <= active ? 21'(pages * boot_cfg_pkg::PAGE_BYTES) : 21'h00_0000;
    end
  end
  assign write_block = write_req && (write_addr < boundary);

  a_block_below_bound: assert property (@(posedge sys_clk) disable iff (rst)
    write_req && write_addr < boundary |-> write_block)
    else $error("write below boundary not blocked");
  a_boot_gate_off: assert property (@(posedge sys_clk) disable iff (rst)
    $past(cfg.loaded) && cfg.word_zero[boot_cfg_pkg::BOOT_PROT_BIT] |-> boundary == 21'h00_0000)
    else $error("boundary set while boot flash unprotected");
  a_all_ones_off: assert property (@(posedge sys_clk) disable iff (rst)
    $past(cfg.loaded) && (&field) |-> !write_block)
    else $error("all ones field still protects");
endmodule : flash_guard
